//--- design/spm_pkg.sv
// Shared constants and types for the sleep and idle power-mode sequencer.
package spm_pkg;

  // Oscillator control input layout.
  localparam int OSC_CTL_W   = 8;
  localparam int SLP_SEL_BIT = 4;
  localparam int OSC_SRC_LSB = 0;
  localparam int OSC_SRC_W   = 2;

  // Widths of the peripheral, priority, divider, pin and start-up counter groups.
  localparam int NUM_PB     = 7;
  localparam int NUM_PERIPH = 8;
  localparam int DIV_W      = 7;
  localparam int PRIO_W     = 3;
  localparam int PIN_W      = 16;
  localparam int WAKE_CNT_W = 12;

  // System clock rate.
  localparam int CLK_MHZ = 125;

  // Oscillator start-up delays applied when Sleep wakes to Run, in nanoseconds.
  localparam int WAKE_FRC_NS  = 100;
  localparam int WAKE_POSC_NS = 2000;
  localparam int WAKE_SOSC_NS = 4000;
  localparam int WAKE_LOW_POWER_RC_OSC_NS = 1000;

  // Delays as whole cycles, rounded up because they are least times.
  localparam logic [WAKE_CNT_W-1:0] WAKE_FRC_CYC  = WAKE_CNT_W'((WAKE_FRC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [WAKE_CNT_W-1:0] WAKE_POSC_CYC = WAKE_CNT_W'((WAKE_POSC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [WAKE_CNT_W-1:0] WAKE_SOSC_CYC = WAKE_CNT_W'((WAKE_SOSC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [WAKE_CNT_W-1:0] WAKE_LOW_POWER_RC_OSC_CYC = WAKE_CNT_W'((WAKE_LOW_POWER_RC_OSC_NS * CLK_MHZ + 999) / 1000);

  // Values after reset.
  localparam logic [NUM_PERIPH-1:0] PERIPH_EN_RST = 8'hff;
  localparam logic [PIN_W-1:0]      PIN_RST       = 16'h0000;
  localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_RST  = 12'h000;
  localparam logic [DIV_W-1:0]      DIV_CNT_RST   = 7'h00;

  // Operating modes of the device.
  typedef enum logic [1:0] {
    SPM_RUN   = 2'b00,
    SPM_IDLE  = 2'b01,
    SPM_SLEEP = 2'b10,
    SPM_WAKE  = 2'b11
  } spm_mode_t;

  // Oscillator sources selectable by software.
  typedef enum logic [1:0] {
    SPM_OSC_FRC  = 2'b00,
    SPM_OSC_POSC = 2'b01,
    SPM_OSC_SOSC = 2'b10,
    SPM_OSC_LOW_POWER_RC_OSC = 2'b11
  } spm_osc_t;

endpackage

//--- design/spm_clk_div.sv
// Clock-enable divider for one peripheral bus or the CPU.
`timescale 1ns/1ps
`default_nettype none
module spm_clk_div
  import spm_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [DIV_W-1:0] div,
  input  wire logic             off,
  input  wire logic             run,
  output logic                  en
);

  logic [DIV_W-1:0] cnt_r;

  // One enable pulse every div+1 cycles; a stopped divider restarts from zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= DIV_CNT_RST;
      en    <= 1'b0;
    end else if (!run || off) begin
      cnt_r <= DIV_CNT_RST;
      en    <= 1'b0;
    end else if (cnt_r >= div) begin
      cnt_r <= DIV_CNT_RST;
      en    <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 7'h01;
      en    <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- design/spm_power_ctl.sv
// Power-mode sequencer moving the core between Run, Idle and Sleep.
//
// Contract
// RL1: Halt with select clear enters Idle.
// RL2: Halt with select set enters Sleep.
// RL3: Sleep stops CPU and most peripheral clocks.
// RL4: Idle halts CPU, clocks keep running.
// RL5: Stop-in-idle peripherals halt on Idle entry.
// RL6: Higher-priority sleep-capable interrupt wakes Sleep.
// RL7: Any reset returns device to Run.
// RL8: Watchdog time-out wakes Sleep and Idle.
// RL9: Low-priority interrupt in Sleep moves to Idle.
// RL10: Low-priority interrupt leaves Idle unchanged.
// RL11: Watchdog not cleared automatically on Sleep.
// RL12: Fail-safe clock monitor off during Sleep.
// RL13: Brown-out detection still resets in Sleep.
// RL14: Sleep-capable peripherals keep clocks in Sleep.
// RL15: Sleep exit waits oscillator-dependent start-up delay.
// RL16: Output pins hold level during Sleep.
// RL17: Peripheral bus clocks divide or switch off.
// RL18: CPU clock slows; oscillator source selectable.
`timescale 1ns/1ps
`default_nettype none
module spm_power_ctl
  import spm_pkg::*;
(
  input  wire logic                    CLK,
  input  wire logic                    RESET,
  input  wire logic                    WAIT_EXEC,
  input  wire logic [OSC_CTL_W-1:0]    OSC_CTL,
  input  wire logic [PRIO_W-1:0]       CPU_PRIO,
  input  wire logic                    IRQ_PEND,
  input  wire logic [PRIO_W-1:0]       IRQ_PRIO,
  input  wire logic                    IRQ_SLEEP_OK,
  input  wire logic                    WDT_TIMEOUT,
  input  wire logic                    WDT_CLR_REQ,
  input  wire logic                    BROWNOUT,
  input  wire logic [NUM_PERIPH-1:0]   STOP_IN_IDLE,
  input  wire logic [NUM_PERIPH-1:0]   SLEEP_CAPABLE,
  input  wire logic [NUM_PB*DIV_W-1:0] PB_DIV,
  input  wire logic [NUM_PB-1:0]       PB_OFF,
  input  wire logic [DIV_W-1:0]        CPU_DIV,
  input  wire logic [PIN_W-1:0]        PIN_OUT_IN,
  output logic      [1:0]              MODE,
  output logic                         CPU_HALT,
  output logic                         CPU_CLK_EN,
  output logic      [NUM_PB-1:0]       PB_CLK_EN,
  output logic      [NUM_PERIPH-1:0]   PERIPH_CLK_EN,
  output logic                         FAIL_SAFE_CLOCK_MONITOR_EN,
  output logic                         BOR_RESET_REQ,
  output logic                         WDT_CLR,
  output logic      [OSC_SRC_W-1:0]    OSC_SEL,
  output logic                         WAKE_DONE,
  output logic      [PIN_W-1:0]        PIN_OUT
);

  spm_mode_t             mode_r;
  spm_mode_t             mode_nxt;
  logic [WAKE_CNT_W-1:0] wake_cnt_r;
  logic [WAKE_CNT_W-1:0] wake_cnt_nxt;
  logic [WAKE_CNT_W-1:0] wake_delay;
  logic                  bor_meta_r;
  logic                  bor_sync_r;
  logic                  hi_prio;
  logic                  sleep_sel;
  logic                  clk_run;
  spm_osc_t              osc_src;

  // Control inputs from the core and interrupt controller share CLK.
  assign sleep_sel = OSC_CTL[SLP_SEL_BIT];
  assign osc_src   = spm_osc_t'(OSC_CTL[OSC_SRC_LSB +: OSC_SRC_W]);
  assign hi_prio   = IRQ_PEND && (IRQ_PRIO > CPU_PRIO);

  // Start-up delay for the oscillator currently selected.
  always_comb begin
    unique case (osc_src)
      SPM_OSC_FRC:  wake_delay = WAKE_FRC_CYC;
      SPM_OSC_POSC: wake_delay = WAKE_POSC_CYC;
      SPM_OSC_SOSC: wake_delay = WAKE_SOSC_CYC;
      SPM_OSC_LOW_POWER_RC_OSC: wake_delay = WAKE_LOW_POWER_RC_OSC_CYC;
    endcase
  end

  // Mode sequencing; the watchdog and interrupt checks stand in priority order.
  always_comb begin
    mode_nxt     = mode_r;
    wake_cnt_nxt = wake_cnt_r;
    unique case (mode_r)
      SPM_RUN: begin
        if (WAIT_EXEC) begin
          mode_nxt = sleep_sel ? SPM_SLEEP : SPM_IDLE; // RL1 RL2
        end
      end
      SPM_IDLE: begin
        // A lower or equal priority request leaves the core halted here.
        if (WDT_TIMEOUT || hi_prio) begin
          mode_nxt = SPM_RUN; // RL8 RL10
        end
      end
      SPM_SLEEP: begin
        if (WDT_TIMEOUT || (hi_prio && IRQ_SLEEP_OK)) begin
          mode_nxt     = SPM_WAKE; // RL6 RL8
          wake_cnt_nxt = wake_delay - 12'h001; // RL15
        end else if (IRQ_PEND && IRQ_SLEEP_OK) begin
          mode_nxt = SPM_IDLE; // RL9
        end
      end
      SPM_WAKE: begin
        if (wake_cnt_r == WAKE_CNT_RST) begin
          mode_nxt = SPM_RUN; // RL15
        end else begin
          wake_cnt_nxt = wake_cnt_r - 12'h001;
        end
      end
    endcase
  end

  // Mode register; the synchronous reset covers every reset source.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      mode_r     <= SPM_RUN; // RL7
      wake_cnt_r <= WAKE_CNT_RST;
    end else begin
      mode_r     <= mode_nxt;
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  // Mode and halt indication to the core, plus the resume pulse.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      MODE      <= SPM_RUN;
      CPU_HALT  <= 1'b0;
      WAKE_DONE <= 1'b0;
    end else begin
      MODE      <= mode_nxt;
      CPU_HALT  <= (mode_nxt != SPM_RUN); // RL3 RL4
      WAKE_DONE <= (mode_r != SPM_RUN) && (mode_nxt == SPM_RUN);
    end
  end

  // Bus and CPU clocks run in Run and Idle; Sleep and the start-up wait stop them.
  assign clk_run = (mode_nxt == SPM_RUN) || (mode_nxt == SPM_IDLE); // RL3 RL4 RL9

  // CPU clock divider lets software trade speed for power while running.
  spm_clk_div u_cpu_div (
    .clk (CLK),
    .rst (RESET),
    .div (CPU_DIV),
    .off (1'b0),
    .run (clk_run),
    .en  (CPU_CLK_EN)
  ); // RL18

  // One divider per peripheral bus; each bus takes its own divide value and off bit.
  genvar gb;
  generate
    for (gb = 0; gb < NUM_PB; gb++) begin : g_pb
      spm_clk_div u_pb_div (
        .clk (CLK),
        .rst (RESET),
        .div (PB_DIV[gb*DIV_W +: DIV_W]),
        .off (PB_OFF[gb]),
        .run (clk_run),
        .en  (PB_CLK_EN[gb])
      ); // RL17 RL18
    end
  endgenerate

  // Per-peripheral clock gates follow the mode the sequencer is moving to.
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PERIPH; gp++) begin : g_periph
      always_ff @(posedge CLK) begin
        if (RESET) begin
          PERIPH_CLK_EN[gp] <= PERIPH_EN_RST[gp];
        end else if (mode_nxt == SPM_RUN) begin
          PERIPH_CLK_EN[gp] <= 1'b1;
        end else if (mode_nxt == SPM_IDLE) begin
          PERIPH_CLK_EN[gp] <= !STOP_IN_IDLE[gp]; // RL5
        end else begin
          PERIPH_CLK_EN[gp] <= SLEEP_CAPABLE[gp]; // RL3 RL14
        end
      end
    end
  endgenerate

  // The clock monitor would flag the stopped clock as a failure, so it rests in Sleep.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      FAIL_SAFE_CLOCK_MONITOR_EN <= 1'b1;
    end else begin
      FAIL_SAFE_CLOCK_MONITOR_EN <= (mode_nxt == SPM_RUN) || (mode_nxt == SPM_IDLE); // RL12
    end
  end

  // Watchdog clears come only from software; mode entry never adds one.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      WDT_CLR <= 1'b0;
    end else begin
      WDT_CLR <= WDT_CLR_REQ; // RL11
    end
  end

  // Brown-out comes from the analog detector, so it is synchronised first.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      bor_meta_r <= 1'b0;
      bor_sync_r <= 1'b0;
    end else begin
      bor_meta_r <= BROWNOUT;
      bor_sync_r <= bor_meta_r;
    end
  end

  // The reset request does not depend on the mode, so it works in Sleep too.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      BOR_RESET_REQ <= 1'b0;
    end else begin
      BOR_RESET_REQ <= bor_sync_r; // RL13
    end
  end

  // The oscillator selection follows software only while the core is running.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      OSC_SEL <= SPM_OSC_FRC;
    end else if (mode_r == SPM_RUN) begin
      OSC_SEL <= osc_src; // RL18
    end
  end

  // Pin levels are frozen in Sleep and during the start-up wait.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PIN_OUT <= PIN_RST;
    end else if ((mode_r == SPM_RUN) || (mode_r == SPM_IDLE)) begin // RL16
      PIN_OUT <= PIN_OUT_IN;
    end
  end

  // Checks on the sequencer, all in the one clock domain.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  idle_entry_a: assert property ( // RL1
    mode_r == SPM_RUN && WAIT_EXEC && !sleep_sel |=> mode_r == SPM_IDLE && CPU_HALT && FAIL_SAFE_CLOCK_MONITOR_EN)
    else $error("halt with select clear did not reach Idle");

  sleep_entry_a: assert property ( // RL2
    mode_r == SPM_RUN && WAIT_EXEC && sleep_sel |=> mode_r == SPM_SLEEP && !FAIL_SAFE_CLOCK_MONITOR_EN)
    else $error("halt with select set did not reach Sleep");

  sleep_clocks_a: assert property ( // RL3
    mode_r == SPM_SLEEP |-> !CPU_CLK_EN && PB_CLK_EN == '0 && CPU_HALT)
    else $error("clocks running in Sleep");

  idle_gates_a: assert property ( // RL5
    mode_r == SPM_RUN && WAIT_EXEC && !sleep_sel |=> PERIPH_CLK_EN == ~$past(STOP_IN_IDLE))
    else $error("stop-in-idle gating wrong on Idle entry");

  sleep_gates_a: assert property ( // RL14
    mode_r == SPM_RUN && WAIT_EXEC && sleep_sel |=> PERIPH_CLK_EN == $past(SLEEP_CAPABLE))
    else $error("sleep-capable gating wrong on Sleep entry");

  sleep_wake_a: assert property ( // RL6
    mode_r == SPM_SLEEP && !WDT_TIMEOUT && hi_prio && IRQ_SLEEP_OK |=> mode_r == SPM_WAKE
    ##[1:600] mode_r == SPM_RUN)
    else $error("high-priority interrupt did not wake from Sleep");

  reset_run_a: assert property ( // RL7
    $fell(RESET) |-> mode_r == SPM_RUN && !CPU_HALT)
    else $error("reset did not return to Run");

  wdt_wake_a: assert property ( // RL8
    mode_r == SPM_IDLE && WDT_TIMEOUT |=> mode_r == SPM_RUN && WAKE_DONE ##1 !WAKE_DONE)
    else $error("watchdog did not end Idle");

  sleep_low_a: assert property ( // RL9
    mode_r == SPM_SLEEP && !WDT_TIMEOUT && IRQ_PEND && IRQ_SLEEP_OK && !hi_prio
    |=> mode_r == SPM_IDLE ##1 CPU_CLK_EN || CPU_DIV != '0 || mode_r != SPM_IDLE)
    else $error("low-priority interrupt did not move Sleep to Idle");

  idle_stay_a: assert property ( // RL10
    mode_r == SPM_IDLE && IRQ_PEND && !hi_prio && !WDT_TIMEOUT |=> mode_r == SPM_IDLE)
    else $error("low-priority interrupt left Idle");

  wdt_noclr_a: assert property ( // RL11
    WDT_CLR |-> $past(WDT_CLR_REQ))
    else $error("watchdog cleared without request");

  fail_safe_clock_monitor_sleep_a: assert property ( // RL12
    mode_r == SPM_SLEEP || mode_r == SPM_WAKE |-> !FAIL_SAFE_CLOCK_MONITOR_EN)
    else $error("clock monitor active in Sleep");

  bor_sleep_a: assert property ( // RL13
    mode_r == SPM_SLEEP && $rose(BROWNOUT) ##1 BROWNOUT ##1 BROWNOUT |=> BOR_RESET_REQ)
    else $error("brown-out did not request reset in Sleep");

  wake_count_a: assert property ( // RL15
    mode_r == SPM_WAKE && wake_cnt_r != WAKE_CNT_RST
    |=> mode_r == SPM_WAKE && wake_cnt_r == $past(wake_cnt_r) - 12'h001)
    else $error("start-up delay miscounted");

  pin_hold_a: assert property ( // RL16
    mode_r == SPM_SLEEP |=> $stable(PIN_OUT))
    else $error("pins changed during Sleep");

  pb_off_a: assert property ( // RL17
    mode_r == SPM_RUN && PB_OFF[0] ##1 PB_OFF[0] |-> !PB_CLK_EN[0])
    else $error("disabled bus clock still running");

  idle_cover_c: cover property (mode_r == SPM_RUN && WAIT_EXEC && !sleep_sel ##1 mode_r == SPM_IDLE);
  sleep_exit_c: cover property (mode_r == SPM_WAKE ##1 mode_r == SPM_RUN);
  sleep_idle_c: cover property (mode_r == SPM_SLEEP ##1 mode_r == SPM_IDLE);
  wdt_sleep_c:  cover property (mode_r == SPM_SLEEP && WDT_TIMEOUT);

endmodule
`default_nettype wire

//--- test/spm_core_model.sv
// Behavioural core, interrupt controller and watchdog facing the power-mode sequencer.
`timescale 1ns/1ps
`default_nettype none
module spm_core_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic halt_req,
  input  wire logic irq_req,
  input  wire logic wdt_req,
  input  wire logic cpu_halt,
  output logic      wait_exec,
  output logic      irq_pend,
  output logic      wdt_timeout
);
  // Halt and time-out are one-cycle events. An interrupt stays pending until the core runs
  // again and services it, so a refused low-priority one lingers as it would on silicon.
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_exec   <= 1'b0;
      irq_pend    <= 1'b0;
      wdt_timeout <= 1'b0;
    end else begin
      wait_exec   <= halt_req;
      wdt_timeout <= wdt_req;
      if (irq_req) begin
        irq_pend <= 1'b1;
      end else if (!cpu_halt) begin
        irq_pend <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/test_spm_power_ctl.sv
// Self-checking bench for the power-mode sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; $display("Error at %0t: got %h expected %h", $time, a, e); end end
module test_spm_power_ctl
  import spm_pkg::*;
;
  localparam logic [11:0] RUN_E = {2'b00, 2'b01, 8'hff};
  logic clk = 1'b0, reset = 1'b1, halt_req = 1'b0, irq_req = 1'b0, wdt_req = 1'b0;
  logic irq_ok = 1'b0, wdt_clr_req = 1'b0, brownout = 1'b0;
  logic [OSC_CTL_W-1:0]    osc_ctl = '0;
  logic [PRIO_W-1:0]       cpu_prio = 3'h3, irq_prio = 3'h3;
  logic [NUM_PERIPH-1:0]   sid = '0, slp = '0, periph_en;
  logic [NUM_PB*DIV_W-1:0] pb_div = '0;
  logic [NUM_PB-1:0]       pb_off = '0, pb_clk_en;
  logic [DIV_W-1:0]        cpu_div = '0;
  logic [PIN_W-1:0]        pin_in = '0, pin_out, held;
  logic [1:0]              mode, prev_mode = 2'b00;
  logic [OSC_SRC_W-1:0]    osc_sel;
  logic [4:0]              n_cpu, n_pb6, n_pb0;
  logic [11:0]             snap, expq[$];
  logic cpu_halt, cpu_clk_en, fail_safe_clock_monitor_en, bor_req, wdt_clr, wake_done, wait_exec, irq_pend, wdt_timeout;
  int miscompares = 0, comparisons = 0, seed = 32'h4a72, wcnt = 0, n, wq[$];
  int dcyc[4] = '{13, 250, 500, 125};

  always #4 clk = ~clk;

  spm_core_model CORE (.clk(clk), .rst(reset), .halt_req(halt_req), .irq_req(irq_req), .wdt_req(wdt_req),
    .cpu_halt(cpu_halt), .wait_exec(wait_exec), .irq_pend(irq_pend), .wdt_timeout(wdt_timeout));
  spm_power_ctl DUT (.CLK(clk), .RESET(reset), .WAIT_EXEC(wait_exec), .OSC_CTL(osc_ctl), .CPU_PRIO(cpu_prio),
    .IRQ_PEND(irq_pend), .IRQ_PRIO(irq_prio), .IRQ_SLEEP_OK(irq_ok), .WDT_TIMEOUT(wdt_timeout),
    .WDT_CLR_REQ(wdt_clr_req), .BROWNOUT(brownout), .STOP_IN_IDLE(sid), .SLEEP_CAPABLE(slp), .PB_DIV(pb_div),
    .PB_OFF(pb_off), .CPU_DIV(cpu_div), .PIN_OUT_IN(pin_in), .MODE(mode), .CPU_HALT(cpu_halt),
    .CPU_CLK_EN(cpu_clk_en), .PB_CLK_EN(pb_clk_en), .PERIPH_CLK_EN(periph_en), .FAIL_SAFE_CLOCK_MONITOR_EN(fail_safe_clock_monitor_en),
    .BOR_RESET_REQ(bor_req), .WDT_CLR(wdt_clr), .OSC_SEL(osc_sel), .WAKE_DONE(wake_done), .PIN_OUT(pin_out));

  // Each mode change takes the oldest note; Wake length is counted here, away from the stimulus.
  always @(negedge clk) begin
    if (!reset && mode !== prev_mode) begin
      if (expq.size() == 0) begin
        snap = 12'hfff;
      end else begin
        snap = expq.pop_front();
      end
      `CHK({mode, cpu_halt, fail_safe_clock_monitor_en, periph_en}, snap)
      `CHK(wake_done, mode === 2'b00)
    end
    if (mode === 2'b11) begin
      wcnt++;
    end else begin
      if (prev_mode === 2'b11 && !reset) `CHK(wcnt, wq.pop_front())
      wcnt = 0;
    end
    prev_mode = mode;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // One halt instruction with the mode select; the note is made before the request leaves.
  task automatic halt(input logic s, input logic [11:0] e);
    osc_ctl[4] <= s;
    expq.push_back(e);
    halt_req <= 1'b1;
    cyc(1);
    halt_req <= 1'b0;
    cyc(4);
  endtask

  task automatic wdt(input logic [11:0] e);
    expq.push_back(e);
    wdt_req <= 1'b1;
    cyc(1);
    wdt_req <= 1'b0;
  endtask

  task automatic pulse_irq;
    irq_req <= 1'b1;
    cyc(1);
    irq_req <= 1'b0;
    cyc(6);
  endtask

  // Bounded wait; the longest start-up delay is well inside the limit.
  task automatic wait_run;
    n = 0;
    while (mode !== 2'b00 && n < 1000) begin
      cyc(1);
      n++;
    end
    `CHK(mode, 2'b00)
    cyc(3);
  endtask

  task finish_test;
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // A hang is cut short at many times the expected run length.
  initial begin
    #(20000 * 8);
    miscompares++;
    finish_test;
  end

  initial begin
    cyc(3);
    reset <= 1'b0;
    pb_div[6*DIV_W +: DIV_W] <= 7'h03;
    pb_off <= 7'h01;
    cpu_div <= 7'h01;
    osc_ctl[1:0] <= 2'h2;
    cyc(6);
    n_cpu = '0;
    n_pb6 = '0;
    n_pb0 = '0;
    repeat (16) begin
      @(negedge clk);
      n_cpu = n_cpu + cpu_clk_en;
      n_pb6 = n_pb6 + pb_clk_en[6];
      n_pb0 = n_pb0 + pb_clk_en[0];
    end
    `CHK(n_cpu, 5'd8)
    `CHK(n_pb6, 5'd4)
    `CHK(n_pb0, 5'd0)
    `CHK(osc_sel, 2'h2)
    cyc(1);
    pb_div <= '0;
    pb_off <= '0;
    cpu_div <= '0;
    sid <= 8'($random(seed));
    slp <= 8'($random(seed));
    $display("test dividers done");
    cyc(2);
    halt(1'b0, {2'b01, 2'b11, ~sid});
    `CHK(cpu_clk_en, 1'b1)
    pulse_irq;
    `CHK(mode, 2'b01)
    wdt(RUN_E);
    wait_run;
    $display("test idle done");
    for (int s = 0; s < 4; s++) begin
      osc_ctl[1:0] <= s[1:0];
      pin_in <= 16'($random(seed));
      slp <= 8'($random(seed));
      cyc(2);
      held = pin_in;
      halt(1'b1, {2'b10, 2'b10, slp});
      `CHK(pb_clk_en, 7'h00)
      `CHK(cpu_clk_en, 1'b0)
      `CHK(wdt_clr, 1'b0)
      pin_in <= ~held;
      wdt_clr_req <= 1'b1;
      cyc(1);
      wdt_clr_req <= 1'b0;
      cyc(1);
      `CHK(wdt_clr, 1'b1)
      `CHK(pin_out, held)
      wq.push_back(dcyc[s]);
      wdt({2'b11, 2'b10, slp});
      expq.push_back(RUN_E);
      wait_run;
    end
    $display("test sleep watchdog done");
    halt(1'b1, {2'b10, 2'b10, slp});
    irq_prio <= 3'h4;
    pulse_irq;
    `CHK(mode, 2'b10)
    expq.push_back({2'b01, 2'b11, ~sid});
    irq_prio <= 3'h3;
    irq_ok <= 1'b1;
    cyc(8);
    `CHK(mode, 2'b01)
    expq.push_back(RUN_E);
    irq_prio <= 3'h4;
    wait_run;
    halt(1'b1, {2'b10, 2'b10, slp});
    wq.push_back(dcyc[3]);
    expq.push_back({2'b11, 2'b10, slp});
    expq.push_back(RUN_E);
    pulse_irq;
    wait_run;
    $display("test sleep interrupt done");
    halt(1'b1, {2'b10, 2'b10, slp});
    brownout <= 1'b1;
    cyc(4);
    `CHK(bor_req, 1'b1)
    `CHK(mode, 2'b10)
    brownout <= 1'b0;
    reset <= 1'b1;
    cyc(3);
    reset <= 1'b0;
    cyc(1);
    `CHK({mode, cpu_halt, fail_safe_clock_monitor_en, periph_en}, RUN_E)
    $display("test reset done");
    finish_test;
  end
endmodule
`default_nettype wire
